//--- rtl/bas_alu.sv
// Functional notes
// - Literal minus accumulator, carry, half, zero
// - File register minus accumulator, carry, half, zero
// - Destination bit 0 accumulator, 1 file register
// - Swap nibbles of file register, no flags
// - Accumulator xor file register, zero flag only
// - Accumulator xor literal into accumulator, zero only
module bas_alu
  import bas_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic exec_in,
  input wire logic [4:0] op_in,
  input wire logic [7:0] literal_in,
  input wire logic [6:0] file_addr_in,
  input wire logic [7:0] file_data_in,
  input wire logic dest_in,
  output logic [7:0] acc_out,
  output logic carry_flag_out,
  output logic half_carry_flag_out,
  output logic zero_flag_out,
  output logic file_we_out,
  output logic [6:0] file_addr_out,
  output logic [7:0] file_wdata_out
);
  import bas_pkg::*;

  logic [7:0] acc;
  logic carry_flag;
  logic half_carry_flag;
  logic zero_flag;
  logic file_we;
  logic [6:0] file_addr;
  logic [7:0] file_wdata;
  logic [7:0] operand;
  logic [7:0] result;
  logic carry_new;
  logic half_carry_new;
  logic zero_new;
  logic is_literal;
  logic is_sub;
  logic is_xor;
  logic valid_op;
  logic to_file;
  logic go;

  assign is_literal = (op_in == literal_minus_acc_op) || (op_in == literal_xor_acc_op);
  assign is_sub = (op_in == literal_minus_acc_op) || (op_in == reg_minus_acc_op);
  assign is_xor = (op_in == reg_xor_acc_op) || (op_in == literal_xor_acc_op);
  assign valid_op = is_sub || is_xor || (op_in == nibble_exchange_op);
  // Unknown op codes are ignored rather than corrupting state
  assign go = clk_en_in && exec_in && valid_op;
  assign operand = is_literal ? literal_in : file_data_in;
  // Literal forms always land in the accumulator
  assign to_file = !is_literal && (dest_in == DEST_FILE);

  bas_compute u_compute (
    .op_in(op_in),
    .acc_in(acc),
    .operand_in(operand),
    .result_out(result),
    .carry_out(carry_new),
    .half_carry_out(half_carry_new),
    .zero_out(zero_new)
  );

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc <= ACC_RESET;
    end else if (go && !to_file) begin
      acc <= result;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carry_flag <= FLAGS_RESET[CARRY_BIT];
      half_carry_flag <= FLAGS_RESET[HALF_CARRY_BIT];
    end else if (go && is_sub) begin
      carry_flag <= carry_new;
      half_carry_flag <= half_carry_new;
    end
  end

  // Swap leaves every flag alone
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zero_flag <= FLAGS_RESET[ZERO_BIT];
    end else if (go && (is_sub || is_xor)) begin
      zero_flag <= zero_new;
    end
  end

  // Write-back strobe lasts until the next clock-enabled cycle, data held until next write
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      file_we <= 1'b0;
      file_addr <= 7'h00;
      file_wdata <= 8'h00;
    end else if (clk_en_in) begin
      file_we <= go && to_file;
      if (go && to_file) begin
        file_addr <= file_addr_in & FILE_ADDR_MAX;
        file_wdata <= result;
      end
    end
  end

  assign acc_out = acc;
  assign carry_flag_out = carry_flag;
  assign half_carry_flag_out = half_carry_flag;
  assign zero_flag_out = zero_flag;
  assign file_we_out = file_we;
  assign file_addr_out = file_addr;
  assign file_wdata_out = file_wdata;
endmodule

//--- rtl/bas_pkg.sv
package bas_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int CARRY_BIT = 0;
  localparam int HALF_CARRY_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  typedef enum logic [4:0] {
    literal_minus_acc_op = 5'h01,
    reg_minus_acc_op = 5'h02,
    nibble_exchange_op = 5'h04,
    reg_xor_acc_op = 5'h08,
    literal_xor_acc_op = 5'h10
  } bas_op_type;
endpackage

//--- rtl/bas_compute.sv
module bas_compute
  import bas_pkg::*;
(
  input wire logic [4:0] op_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] operand_in,
  output logic [7:0] result_out,
  output logic carry_out,
  output logic half_carry_out,
  output logic zero_out
);
  logic [8:0] diff;
  logic [4:0] low_diff;

  // Borrow-free subtract: add inverted acc plus one
  assign diff = {1'b0, operand_in} + {1'b0, ~acc_in} + 9'h001;
  assign low_diff = {1'b0, operand_in[3:0]} + {1'b0, ~acc_in[3:0]} + 5'h01;

  always_comb begin
    result_out = operand_in;
    case (op_in)
      literal_minus_acc_op, reg_minus_acc_op: result_out = diff[7:0];
      nibble_exchange_op: result_out = {operand_in[3:0], operand_in[7:4]};
      reg_xor_acc_op, literal_xor_acc_op: result_out = acc_in ^ operand_in;
      default: result_out = operand_in;
    endcase
  end

  assign carry_out = diff[8];
  assign half_carry_out = low_diff[4];
  assign zero_out = (result_out == ZERO_BYTE);
endmodule

//--- testbench/bas_alu_checker.sv
module bas_alu_checker
(input wire logic sys_clk_in, rst_n_in, clk_en_in, exec_in, dest_in, file_we_out,
  carry_flag_out, half_carry_flag_out, zero_flag_out,
  input wire logic [4:0] op_in,
  input wire logic [7:0] literal_in, file_data_in, acc_out, file_wdata_out);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] a, k, f;
  // Only legal one-hot codes count as taken
  wire [4:0] o = clk_en_in && exec_in && $onehot(op_in) ? op_in : 5'h00;
  always_ff @(posedge sys_clk_in) {a, k, f} <= {acc_out, literal_in, file_data_in};
  lit_sub_a:
    assert property (o[0] |=> acc_out == k - a && carry_flag_out == k >= a) else $error("lsub");
  reg_sub_a:
    assert property (o[1] && dest_in |=> file_wdata_out == f - a
      && half_carry_flag_out == f[3:0] >= a[3:0]) else $error("fsub");
  to_acc_a:
    assert property (o[1] && !dest_in |=> !file_we_out && acc_out == f - a) else $error("dst");
  swap_a:
    assert property (o[2] && !dest_in |=> acc_out == {f[3:0], f[7:4]}
      && $stable({carry_flag_out, zero_flag_out})) else $error("swp");
  reg_xor_a:
    assert property (o[3] && dest_in |=> file_wdata_out == (f ^ a) && $stable(acc_out))
      else $error("fxor");
  lit_xor_a:
    assert property (o[4] |=> acc_out == (k ^ a) && $stable(carry_flag_out)) else $error("lxor");
  xor_zero_a:
    assert property (o[3] && !dest_in |=> zero_flag_out == (f == a)) else $error("zro");
endmodule
bind bas_alu bas_alu_checker bas_alu_checker_inst(.*);

//--- testbench/bas_file_model.sv
module bas_file_model
(input wire logic clk_in, we_in,
  input wire logic [6:0] ra_in, wa_in,
  input wire logic [7:0] wd_in,
  output logic [7:0] rd_out);
  timeunit 1ns; timeprecision 1ns;
  logic [7:0] mem [128];
  initial foreach (mem[i]) mem[i] = 8'(i * 29);
  always @(posedge clk_in) if (we_in) mem[wa_in] <= wd_in;
  assign rd_out = mem[ra_in];
endmodule

//--- testbench/bas_alu_tb.sv
module bas_alu_tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, rn = 0, en = 0, ex = 0, d = 0, c, h, z, we, ew = 0, ok;
  logic [4:0] op = 0;
  logic [6:0] a = 0, wa, eaddr = 0;
  logic [7:0] k = 0, fd, acc, wd, ea = 0, ed = 0, x, r;
  logic [2:0] ef = 0;
  logic [26:0] q[$];
  logic [31:0] s = 32'h1ec6_50a4;
  int num_errors = 0, n_checks = 0;
  bas_alu bas_alu_inst(.sys_clk_in(clk), .rst_n_in(rn), .clk_en_in(en), .exec_in(ex),
    .op_in(op), .literal_in(k), .file_addr_in(a), .file_data_in(fd), .dest_in(d),
    .acc_out(acc), .carry_flag_out(c), .half_carry_flag_out(h), .zero_flag_out(z),
    .file_we_out(we), .file_addr_out(wa), .file_wdata_out(wd));
  bas_file_model bas_file_model_inst(.clk_in(clk), .we_in(we), .ra_in(a), .wa_in(wa),
    .wd_in(wd), .rd_out(fd));
  task check(input logic [26:0] g, e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t alu state", $time);
    end
  endtask
  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function void step(); s ^= s << 13; s ^= s >> 17; s ^= s << 5; endfunction
  initial forever #10 clk = ~clk;
  initial begin #20us; num_errors++; conclude(); end
  always @(posedge clk)
    if (q.size()) #1 check({acc, c, h, z, we, wd, wa}, q.pop_front());
  initial begin
    repeat (2) @(posedge clk);
    #2 rn = 1;
    repeat (600) begin
      @(posedge clk);
      #2 step();
      // Literal equal to acc forces zero results
      {en, ex, d, a, k} = {|s[2:0], s[3], s[4], s[11:5], s[12] ? ea : s[31:24]};
      op = 5'(1 << s[15:13] % 6);
      #1 x = op[0] | op[4] ? k : fd;
      ok = en && ex && op;
      r = ea;
      if (ok) case (op)
        1, 2: {r, ef} = {x - ea, x >= ea, x[3:0] >= ea[3:0], x == ea};
        4: r = {x[3:0], x[7:4]};
        8, 16: {r, ef[0]} = {x ^ ea, x == ea};
      endcase
      if (en) ew = ok && d && !op[0] && !op[4];
      if (ok && ew) {ed, eaddr} = {r, a};
      else if (ok) ea = r;
      q.push_back({ea, ef, ew, ed, eaddr});
    end
    @(posedge clk);
    #2 conclude();
  end
endmodule
